// ==== core/tcc_top.sv ====
/*
 * 16-bit timer/counter with two capture/compare registers, Avalon-MM slave.
 * Assumes sys_clk is fx; the capture pin is asynchronous; one bus master.
 */
`timescale 1ns/10ps
`include "tcc_consts.svh"
module tcc_top
    import tcc_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int PRE_W = 9
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic capture_input_a,
    output logic timer_output_pin,
    output logic match_a_irq,
    output logic capture_b_irq
);
    // ==========================================================
    // State
    // Longest wait from a capture to its irq, in fx cycles
    localparam int IRQ_WAIT_MAX = `TCC_IRQ_WAIT_MAX;
    logic [1:0] run_mode_reg;
    logic overflow_flag_reg;
    logic [2:0] cc_ctrl_reg;
    logic [3:0] out_ctrl_reg;
    logic [1:0] cks_reg;
    logic [1:0] edge_sel_reg;
    logic [DATA_W-1:0] main_counter_reg;
    logic [DATA_W-1:0] main_counter_next;
    logic [DATA_W-1:0] cc_a_reg;
    logic [DATA_W-1:0] cc_b_reg;
    logic pend_a_reg;
    logic pend_b_reg;
    logic irqp_a_reg;
    logic irqp_b_reg;
    logic level_reg;
    logic level_next;
    tcc_os_state_type os_state_reg;
    tcc_os_state_type os_state_next;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic match_a_irq_reg;
    logic capture_b_irq_reg;
    logic pin_reg;
    // ==========================================================
    // Count clock and input filter
    wire running = (run_mode_reg != `TCC_RUN_STOP);
    wire event_mode = (cks_reg == `TCC_CKS_EVENT);
    wire pre_rise;
    wire pre_fall;
    wire in_rise;
    wire in_fall;
    tcc_prescaler #(.CNT_W(PRE_W)) u_pre (
        .sys_clk(sys_clk),
        .srst(srst),
        .run(running),
        .sel(cks_reg),
        .rise_pulse(pre_rise),
        .fall_pulse(pre_fall)
    );
    tcc_edge_filter u_filt (
        .sys_clk(sys_clk),
        .srst(srst),
        .pin_raw(capture_input_a),
        .sample_en(running && (event_mode || pre_rise)),
        .rise_pulse(in_rise),
        .fall_pulse(in_fall)
    );
    // ==========================================================
    // Edge selection
    wire sel_edge = ((edge_sel_reg == `TCC_ES_BOTH) && (in_rise || in_fall))
                 || ((edge_sel_reg == `TCC_ES_RISE) && in_rise)
                 || ((edge_sel_reg == `TCC_ES_FALL) && in_fall);
    wire inv_edge = ((edge_sel_reg == `TCC_ES_RISE) && in_fall)
                 || ((edge_sel_reg == `TCC_ES_FALL) && in_rise);
    wire a_capt = cc_ctrl_reg[`TCC_CCA_CAPT];
    wire a_inv = cc_ctrl_reg[`TCC_CCA_INV];
    wire b_capt = cc_ctrl_reg[`TCC_CCB_CAPT];
    wire oe = out_ctrl_reg[0];
    wire tog_a = out_ctrl_reg[1];
    wire tog_b = out_ctrl_reg[2];
    wire os_en = out_ctrl_reg[3];
    // ==========================================================
    // Bus decode
    wire req = avs_read || avs_write;
    wire acc = req && !wait_reg;
    wire wr = acc && avs_write;
    wire wr_mode = wr && (avs_address == `TCC_ADDR_MODE) && avs_byteenable[0];
    wire wr_cctrl = wr && (avs_address == `TCC_ADDR_CCTRL) && avs_byteenable[0];
    wire wr_outc = wr && (avs_address == `TCC_ADDR_OUTC) && avs_byteenable[0];
    wire wr_presc = wr && (avs_address == `TCC_ADDR_PRESC) && avs_byteenable[0];
    wire wr_cca = wr && (avs_address == `TCC_ADDR_CCA);
    wire wr_ccb = wr && (avs_address == `TCC_ADDR_CCB);
    wire [DATA_W-1:0] wd_a = {avs_byteenable[1] ? avs_writedata[15:8] : cc_a_reg[15:8],
                              avs_byteenable[0] ? avs_writedata[7:0] : cc_a_reg[7:0]};
    wire [DATA_W-1:0] wd_b = {avs_byteenable[1] ? avs_writedata[15:8] : cc_b_reg[15:8],
                              avs_byteenable[0] ? avs_writedata[7:0] : cc_b_reg[7:0]};
    wire [31:0] rd_mux =
        (avs_address == `TCC_ADDR_MODE) ? {28'h0000000, run_mode_reg, 1'b0, overflow_flag_reg} :
        (avs_address == `TCC_ADDR_CCTRL) ? {29'h0000000, cc_ctrl_reg} :
        (avs_address == `TCC_ADDR_OUTC) ? {26'h000000, os_en, tog_b, 2'h0, tog_a, oe} :
        (avs_address == `TCC_ADDR_PRESC) ? {26'h000000, edge_sel_reg, 2'h0, cks_reg} :
        (avs_address == `TCC_ADDR_COUNT) ? {16'h0000, main_counter_reg} :
        (avs_address == `TCC_ADDR_CCA) ? {16'h0000, cc_a_reg} :
        (avs_address == `TCC_ADDR_CCB) ? {16'h0000, cc_b_reg} : 32'h00000000;
    // ==========================================================
    // Counting, compare and capture events
    wire step = running && (event_mode ? sel_edge : pre_rise);
    wire match_a = step && !a_capt && (main_counter_reg == cc_a_reg);
    wire match_b = step && !b_capt && (main_counter_reg == cc_b_reg);
    wire do_cap_b = pend_b_reg && pre_fall;
    wire do_cap_a = pend_a_reg && pre_fall;
    wire restart_clr = do_cap_b && (run_mode_reg == `TCC_RUN_RESTART);
    wire sw_trig = wr_outc && avs_writedata[`TCC_OSTRIG_BIT];
    wire ext_trig = os_en && running && !event_mode && sel_edge
                    && (os_state_reg != TCC_OS_PULSE);
    wire start = sw_trig || ext_trig;
    wire b_first = (cc_b_reg < cc_a_reg);
    wire os_on = b_first ? match_b : match_a;
    wire os_off = b_first ? match_a : match_b;
    wire wrap = step && (main_counter_reg == `TCC_ALL_ONES);
    always_comb begin
        main_counter_next = main_counter_reg;
        if (!running || start || restart_clr) main_counter_next = `TCC_ZERO16;
        else if (step && (run_mode_reg == `TCC_RUN_MATCHCLR) && match_a)
            main_counter_next = `TCC_ZERO16;
        else if (step) main_counter_next = main_counter_reg + `TCC_ONE16;
    end
    always_comb begin
        level_next = level_reg;
        os_state_next = os_state_reg;
        if (start) begin
            level_next = 1'b0;
            os_state_next = TCC_OS_PRE;
        end else if (os_en) begin
            case (os_state_reg)
                TCC_OS_PRE: begin
                    if (os_on) begin
                        level_next = 1'b1;
                        os_state_next = TCC_OS_PULSE;
                    end
                end
                TCC_OS_PULSE: begin
                    if (os_off) begin
                        level_next = 1'b0;
                        os_state_next = TCC_OS_IDLE;
                    end
                end
                default: os_state_next = TCC_OS_IDLE;
            endcase
        end else begin
            if (tog_a && match_a) level_next = !level_next;
            if (tog_b && match_b) level_next = !level_next;
        end
    end
    // ==========================================================
    // Bus slave: one wait state, then a one-cycle answer
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wait_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else begin
            wait_reg <= !(req && wait_reg);
            if (req && wait_reg) rdata_reg <= avs_read ? rd_mux : 32'h00000000;
        end
    end
    // ==========================================================
    // Control registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            run_mode_reg <= `TCC_RUN_STOP;
            cc_ctrl_reg <= 3'h0;
            out_ctrl_reg <= 4'h0;
            cks_reg <= `TCC_CKS_DIV1;
            edge_sel_reg <= `TCC_ES_FALL;
        end else begin
            if (wr_mode) run_mode_reg <= avs_writedata[`TCC_RUN_HI:`TCC_RUN_LO];
            if (wr_cctrl) cc_ctrl_reg <= avs_writedata[`TCC_CCB_CAPT:`TCC_CCA_CAPT];
            if (wr_outc) out_ctrl_reg <= {avs_writedata[`TCC_OSEN_BIT],
                avs_writedata[`TCC_TOGB_BIT], avs_writedata[`TCC_TOGA_BIT],
                avs_writedata[`TCC_OE_BIT]};
            if (wr_presc) begin
                cks_reg <= avs_writedata[`TCC_CKS_HI:`TCC_CKS_LO];
                edge_sel_reg <= avs_writedata[`TCC_ES_HI:`TCC_ES_LO];
            end
        end
    end
    // ==========================================================
    // Overflow flag: hardware set beats software clear
    always_ff @(posedge sys_clk) begin
        if (srst) overflow_flag_reg <= 1'b0;
        else if (wrap) overflow_flag_reg <= 1'b1;
        else if (wr_mode && !avs_writedata[`TCC_OVF_BIT]) overflow_flag_reg <= 1'b0;
    end
    // ==========================================================
    // Counter and capture/compare registers; capture beats bus write
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            main_counter_reg <= `TCC_ZERO16;
            cc_a_reg <= `TCC_ZERO16;
            cc_b_reg <= `TCC_ZERO16;
        end else begin
            main_counter_reg <= main_counter_next;
            if (do_cap_a) cc_a_reg <= main_counter_reg;
            else if (wr_cca) cc_a_reg <= wd_a;
            if (do_cap_b) cc_b_reg <= main_counter_reg;
            else if (wr_ccb) cc_b_reg <= wd_b;
        end
    end
    // ==========================================================
    // Capture pending and interrupt pending
    always_ff @(posedge sys_clk) begin
        if (srst || !running) begin
            pend_a_reg <= 1'b0;
            pend_b_reg <= 1'b0;
            irqp_a_reg <= 1'b0;
            irqp_b_reg <= 1'b0;
        end else begin
            if (!event_mode && b_capt && sel_edge) pend_b_reg <= 1'b1;
            else if (do_cap_b) pend_b_reg <= 1'b0;
            if (!event_mode && a_capt && a_inv && inv_edge) pend_a_reg <= 1'b1;
            else if (do_cap_a) pend_a_reg <= 1'b0;
            if (do_cap_b) irqp_b_reg <= 1'b1;
            else if (pre_rise) irqp_b_reg <= 1'b0;
            if (do_cap_a) irqp_a_reg <= 1'b1;
            else if (pre_rise) irqp_a_reg <= 1'b0;
        end
    end
    // ==========================================================
    // Output pin, one-shot state and interrupt pulses
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            level_reg <= 1'b0;
            os_state_reg <= TCC_OS_IDLE;
            pin_reg <= 1'b0;
            match_a_irq_reg <= 1'b0;
            capture_b_irq_reg <= 1'b0;
        end else begin
            level_reg <= level_next;
            os_state_reg <= os_state_next;
            pin_reg <= oe && level_next;
            match_a_irq_reg <= match_a || (irqp_a_reg && pre_rise && !do_cap_a);
            capture_b_irq_reg <= match_b || (irqp_b_reg && pre_rise && !do_cap_b);
        end
    end
    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign timer_output_pin = pin_reg;
    assign match_a_irq = match_a_irq_reg;
    assign capture_b_irq = capture_b_irq_reg;
    // ==========================================================
    // Checks
    a_bus_one_wait: assert property (@(posedge sys_clk) disable iff (srst)
        (req && wait_reg) |=> !wait_reg ##1 wait_reg)
        else $error("bus answer not one cycle after request");
    a_ovf_on_wrap: assert property (@(posedge sys_clk) disable iff (srst)
        wrap |=> overflow_flag_reg && main_counter_reg == `TCC_ZERO16)
        else $error("counter wrap did not set overflow");
    a_cap_b_value: assert property (@(posedge sys_clk) disable iff (srst)
        do_cap_b |=> cc_b_reg == $past(main_counter_reg))
        else $error("register B did not capture counter");
    a_cap_a_value: assert property (@(posedge sys_clk) disable iff (srst)
        do_cap_a |=> cc_a_reg == $past(main_counter_reg))
        else $error("register A did not capture counter");
    a_irq_after_cap: assert property (@(posedge sys_clk) disable iff (srst || !running)
        do_cap_b |-> !capture_b_irq_reg ##[1:IRQ_WAIT_MAX] capture_b_irq_reg)
        else $error("capture irq not raised at next count clock rise");
    a_restart_clear: assert property (@(posedge sys_clk) disable iff (srst)
        restart_clr |=> main_counter_reg == `TCC_ZERO16)
        else $error("restart capture did not clear counter");
    a_event_count: assert property (@(posedge sys_clk) disable iff (srst)
        (event_mode && step && !start && !match_a)
        |=> main_counter_reg == $past(main_counter_reg) + `TCC_ONE16)
        else $error("event edge did not advance counter");
    a_match_clear: assert property (@(posedge sys_clk) disable iff (srst)
        (run_mode_reg == `TCC_RUN_MATCHCLR && match_a && !start)
        |=> main_counter_reg == `TCC_ZERO16 && match_a_irq_reg)
        else $error("match A did not clear counter and raise irq");
    a_square_toggle: assert property (@(posedge sys_clk) disable iff (srst)
        (oe && tog_a && match_a && !match_b && !os_en && !start)
        |=> timer_output_pin != $past(timer_output_pin))
        else $error("output did not invert on match A");
    a_oneshot_start: assert property (@(posedge sys_clk) disable iff (srst)
        sw_trig |=> main_counter_reg == `TCC_ZERO16 && os_state_reg == TCC_OS_PRE)
        else $error("one-shot trigger did not clear and arm");
    a_pin_needs_enable: assert property (@(posedge sys_clk) disable iff (srst)
        !oe |=> !timer_output_pin)
        else $error("timer output driven while output disabled");
    a_oneshot_on: assert property (@(posedge sys_clk) disable iff (srst)
        (os_en && !start && os_state_reg == TCC_OS_PRE && os_on)
        |=> level_reg && os_state_reg == TCC_OS_PULSE)
        else $error("one-shot pulse did not go active");
    a_oneshot_off: assert property (@(posedge sys_clk) disable iff (srst)
        (os_en && !start && os_state_reg == TCC_OS_PULSE && os_off)
        |=> !level_reg && os_state_reg == TCC_OS_IDLE)
        else $error("one-shot pulse did not go inactive");
    a_ext_trig_restart: assert property (@(posedge sys_clk) disable iff (srst)
        ext_trig |=> main_counter_reg == `TCC_ZERO16 && os_state_reg == TCC_OS_PRE)
        else $error("pin edge did not restart one-shot");
    a_stop_holds_zero: assert property (@(posedge sys_clk) disable iff (srst)
        !running |=> main_counter_reg == `TCC_ZERO16)
        else $error("stopped counter not held at zero");
    a_match_irq: assert property (@(posedge sys_clk) disable iff (srst)
        match_a |=> match_a_irq_reg)
        else $error("match A did not raise irq");
    a_cap_a_irq: assert property (@(posedge sys_clk) disable iff (srst || !running)
        do_cap_a |-> !match_a_irq_reg ##[1:IRQ_WAIT_MAX] match_a_irq_reg)
        else $error("capture A irq not raised at next count clock rise");
    a_ovf_sw_clear: assert property (@(posedge sys_clk) disable iff (srst)
        (wr_mode && !avs_writedata[`TCC_OVF_BIT] && !wrap) |=> !overflow_flag_reg)
        else $error("software clear of overflow lost");
    a_write_reads_zero: assert property (@(posedge sys_clk) disable iff (srst)
        (avs_write && wait_reg) |=> avs_readdata == 32'h00000000)
        else $error("write answer carried read data");
endmodule : tcc_top

// ==== core/tcc_consts.svh ====
/*
 * Register offsets, field positions, codes and limits of the capture/compare timer.
 * Assumes inclusion by bare name from the core files.
 */
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH
// ==========================================================
// Register byte offsets
`define TCC_ADDR_MODE 5'h00
`define TCC_ADDR_CCTRL 5'h04
`define TCC_ADDR_OUTC 5'h08
`define TCC_ADDR_PRESC 5'h0C
`define TCC_ADDR_COUNT 5'h10
`define TCC_ADDR_CCA 5'h14
`define TCC_ADDR_CCB 5'h18
// ==========================================================
// Field positions
`define TCC_OVF_BIT 0
`define TCC_RUN_LO 2
`define TCC_RUN_HI 3
`define TCC_CCA_CAPT 0
`define TCC_CCA_INV 1
`define TCC_CCB_CAPT 2
`define TCC_OE_BIT 0
`define TCC_TOGA_BIT 1
`define TCC_TOGB_BIT 4
`define TCC_OSEN_BIT 5
`define TCC_OSTRIG_BIT 6
`define TCC_CKS_LO 0
`define TCC_CKS_HI 1
`define TCC_ES_LO 4
`define TCC_ES_HI 5
// ==========================================================
// Codes and values
`define TCC_RUN_STOP 2'h0
`define TCC_RUN_RESTART 2'h1
`define TCC_RUN_FREE 2'h2
`define TCC_RUN_MATCHCLR 2'h3
`define TCC_ES_FALL 2'h0
`define TCC_ES_RISE 2'h1
`define TCC_ES_BOTH 2'h3
`define TCC_CKS_DIV1 2'h0
`define TCC_CKS_DIV4 2'h1
`define TCC_CKS_DIV256 2'h2
`define TCC_CKS_EVENT 2'h3
`define TCC_DIV1 9'h001
`define TCC_DIV4 9'h004
`define TCC_DIV256 9'h100
`define TCC_ALL_ONES 16'hFFFF
`define TCC_ZERO16 16'h0000
`define TCC_ONE16 16'h0001
`define TCC_IRQ_WAIT_MAX 260
`endif

// ==== core/tcc_pkg.sv ====
/*
 * Types shared by the capture/compare timer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tcc_pkg;
    typedef enum logic [1:0] {TCC_OS_IDLE, TCC_OS_PRE, TCC_OS_PULSE} tcc_os_state_type;
endpackage : tcc_pkg

// ==== core/tcc_prescaler.sv ====
/*
 * Count clock generator: rise and fall pulses of the count clock at fx, fx/4, fx/256.
 * Assumes sys_clk is fx; held at phase zero while the timer is stopped.
 */
`timescale 1ns/10ps
`include "tcc_consts.svh"
module tcc_prescaler #(
    parameter int CNT_W = 9
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic run,
    input wire logic [1:0] sel,
    output logic rise_pulse,
    output logic fall_pulse
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    wire [CNT_W-1:0] div = (sel == `TCC_CKS_DIV4) ? CNT_W'(`TCC_DIV4) :
                           (sel == `TCC_CKS_DIV256) ? CNT_W'(`TCC_DIV256) : CNT_W'(`TCC_DIV1);
    wire wrap = (cnt_reg >= div - CNT_W'(1));
    assign cnt_next = (!run || wrap) ? '0 : cnt_reg + CNT_W'(1);
    assign rise_pulse = run && (cnt_reg == '0);
    assign fall_pulse = run && (cnt_reg == (div >> 1));
    // ==========================================================
    // Phase counter
    always_ff @(posedge sys_clk) begin
        if (srst) cnt_reg <= '0;
        else cnt_reg <= cnt_next;
    end
endmodule : tcc_prescaler

// ==== core/tcc_edge_filter.sv ====
/*
 * Synchroniser and two-sample noise filter for the capture input pin.
 * Assumes an asynchronous pin; sample_en paces the sampling.
 */
`timescale 1ns/10ps
module tcc_edge_filter (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic pin_raw,
    input wire logic sample_en,
    output logic rise_pulse,
    output logic fall_pulse
);
    logic sync_a_reg;
    logic sync_b_reg;
    logic samp_reg;
    logic lvl_reg;
    wire stable = sample_en && (sync_b_reg == samp_reg);
    assign rise_pulse = stable && samp_reg && !lvl_reg;
    assign fall_pulse = stable && !samp_reg && lvl_reg;
    // ==========================================================
    // Synchroniser and sampler
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync_a_reg <= 1'b0;
            sync_b_reg <= 1'b0;
            samp_reg <= 1'b0;
            lvl_reg <= 1'b0;
        end else begin
            sync_a_reg <= pin_raw;
            sync_b_reg <= sync_a_reg;
            if (sample_en) samp_reg <= sync_b_reg;
            if (stable) lvl_reg <= samp_reg;
        end
    end
    a_filter_two_samples: assert property (@(posedge sys_clk) disable iff (srst)
        (rise_pulse || fall_pulse) |-> (sample_en && samp_reg == sync_b_reg
                                         && lvl_reg != sync_b_reg))
        else $error("edge accepted without two equal samples");
endmodule : tcc_edge_filter

// ==== sim/tcc_pin_model.sv ====
/*
 * Pulse source on the capture pin and load on the timer output.
 * Assumes the bench calls pulse() right after a rising edge of sys_clk.
 */
`timescale 1ns/10ps
module tcc_pin_model (
    input wire logic sys_clk,
    output logic pin,
    input wire logic tout
);
    logic tout_seen;
    initial pin = 1'b0;
    // ==========================================================
    // Stimulus
    // Each level lasts longer than two count clocks
    task pulse(input int hi, input int lo);
        pin <= 1'b1;
        repeat (hi) @(posedge sys_clk);
        pin <= 1'b0;
        repeat (lo) @(posedge sys_clk);
    endtask : pulse
    always @(posedge sys_clk) tout_seen <= tout;
endmodule : tcc_pin_model

// ==== sim/tb_top.sv ====
/*
 * Self-checking bench of the capture/compare timer over Avalon-MM.
 * Assumes the design files in core/ and the pin model in sim/.
 */
`timescale 1ns/10ps
`include "tcc_consts.svh"
module tb_top;
    logic sys_clk, srst, avs_read, avs_write, avs_waitrequest;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rv, rw;
    logic capture_input_a, timer_output_pin, match_a_irq, capture_b_irq;
    int bad_count = 0;
    int tests_run = 0;
    int c;
    tcc_top i_tcc_top (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .capture_input_a(capture_input_a),
        .timer_output_pin(timer_output_pin), .match_a_irq(match_a_irq),
        .capture_b_irq(capture_b_irq));
    tcc_pin_model i_tcc_pin_model (.sys_clk(sys_clk), .pin(capture_input_a),
        .tout(timer_output_pin));
    // ==========================================================
    // Bus master and helpers
    task bus(input logic rd, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= ~rd;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask : bus
    task wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b0, a, d, rw);
    endtask : wr
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task rdchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b1, a, 32'h0000_0000, rv);
        chk(rv, exp);
    endtask : rdchk
    // Cycles until a watched signal is seen high; 0 when not seen before cycle lim
    task wait_for(input int w, input int lim, output int n);
        logic s;
        n = 0;
        while (n < lim) begin
            @(posedge sys_clk);
            n++;
            s = (w == 0) ? match_a_irq : (w == 1) ? capture_b_irq :
                (w == 2) ? timer_output_pin : ~timer_output_pin;
            if (s === 1'b1) break;
        end
        if (n >= lim) n = 0;
    endtask : wait_for
    task give_verdict;
        $display("compares %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    // ==========================================================
    // Scenarios
    task t_regs;
        rdchk(`TCC_ADDR_MODE, 32'h0000_0000);
        wr(5'h1C, 32'h0000_FFFF);
        rdchk(5'h1C, 32'h0000_0000);
        wr(`TCC_ADDR_COUNT, 32'h0000_1234);
        rdchk(`TCC_ADDR_COUNT, 32'h0000_0000);
        wr(`TCC_ADDR_CCA, 32'hFFFF_ABCD);
        rdchk(`TCC_ADDR_CCA, 32'h0000_ABCD);
        wr(`TCC_ADDR_OUTC, 32'h0000_0073);
        rdchk(`TCC_ADDR_OUTC, 32'h0000_0033);
        wr(`TCC_ADDR_PRESC, 32'h0000_0033);
        rdchk(`TCC_ADDR_PRESC, 32'h0000_0033);
        wr(`TCC_ADDR_CCTRL, 32'h0000_0007);
        rdchk(`TCC_ADDR_CCTRL, 32'h0000_0007);
        wr(`TCC_ADDR_OUTC, 32'h0000_0000);
        wr(`TCC_ADDR_PRESC, 32'h0000_0000);
        wr(`TCC_ADDR_CCTRL, 32'h0000_0000);
    endtask : t_regs
    task t_square;
        wr(`TCC_ADDR_CCA, 32'h0000_0004);
        wr(`TCC_ADDR_OUTC, 32'h0000_0003);
        wr(`TCC_ADDR_MODE, 32'h0000_000C);
        wait_for(2, 40, c);
        wait_for(3, 40, c);
        chk(c, 5);
        wr(`TCC_ADDR_MODE, 32'h0000_0000);
        wr(`TCC_ADDR_OUTC, 32'h0000_0000);
    endtask : t_square
    task t_event;
        wr(`TCC_ADDR_PRESC, 32'h0000_0013);
        // Match at count 2: the third edge clears
        wr(`TCC_ADDR_CCA, 32'h0000_0002);
        wr(`TCC_ADDR_MODE, 32'h0000_000C);
        i_tcc_pin_model.pulse(6, 6);
        i_tcc_pin_model.pulse(6, 6);
        rdchk(`TCC_ADDR_COUNT, 32'h0000_0002);
        fork
            i_tcc_pin_model.pulse(6, 6);
            wait_for(0, 40, c);
        join
        chk(c != 0, 1'b1);
        rdchk(`TCC_ADDR_COUNT, 32'h0000_0000);
        wr(`TCC_ADDR_MODE, 32'h0000_0000);
    endtask : t_event
    task t_capture;
        logic [31:0] b;
        wr(`TCC_ADDR_CCTRL, 32'h0000_0007);
        wr(`TCC_ADDR_PRESC, 32'h0000_0010);
        wr(`TCC_ADDR_MODE, 32'h0000_0008);
        fork
            i_tcc_pin_model.pulse(20, 10);
            begin
                wait_for(1, 30, c);
                chk(c != 0, 1'b1);
                wait_for(0, 30, c);
                chk(c != 0, 1'b1);
            end
        join
        bus(1'b1, `TCC_ADDR_CCB, 32'h0000_0000, b);
        bus(1'b1, `TCC_ADDR_CCA, 32'h0000_0000, rv);
        chk({16'h0000, rv[15:0] - b[15:0]}, 32'h0000_0014);
        wr(`TCC_ADDR_MODE, 32'h0000_0000);
        wr(`TCC_ADDR_CCTRL, 32'h0000_0000);
    endtask : t_capture
    task t_restart;
        wr(`TCC_ADDR_CCTRL, 32'h0000_0004);
        wr(`TCC_ADDR_PRESC, 32'h0000_0010);
        wr(`TCC_ADDR_MODE, 32'h0000_0004);
        i_tcc_pin_model.pulse(20, 10);
        fork
            i_tcc_pin_model.pulse(20, 10);
            wait_for(1, 30, c);
        join
        chk(c != 0, 1'b1);
        // 30 ticks between rises; the clearing tick counts no value
        rdchk(`TCC_ADDR_CCB, 32'h0000_001D);
        wr(`TCC_ADDR_MODE, 32'h0000_0000);
        wr(`TCC_ADDR_CCTRL, 32'h0000_0000);
    endtask : t_restart
    task t_oneshot;
        wr(`TCC_ADDR_PRESC, 32'h0000_0000);
        wr(`TCC_ADDR_CCA, 32'h0000_0014);
        wr(`TCC_ADDR_CCB, 32'h0000_0008);
        wr(`TCC_ADDR_MODE, 32'h0000_0008);
        wr(`TCC_ADDR_OUTC, 32'h0000_0061);
        wait_for(2, 60, c);
        chk(c != 0, 1'b1);
        wait_for(3, 60, c);
        chk(c, 12);
        bus(1'b1, `TCC_ADDR_COUNT, 32'h0000_0000, rv);
        chk(rv !== 32'h0000_0000, 1'b1);
        fork
            i_tcc_pin_model.pulse(4, 4);
            wait_for(2, 60, c);
        join
        chk(c != 0, 1'b1);
        wait_for(3, 60, c);
        chk(c, 12);
        wr(`TCC_ADDR_MODE, 32'h0000_0000);
        rdchk(`TCC_ADDR_COUNT, 32'h0000_0000);
    endtask : t_oneshot
    task t_overflow;
        wr(`TCC_ADDR_MODE, 32'h0000_0008);
        rdchk(`TCC_ADDR_MODE, 32'h0000_0008);
        repeat (65540) @(posedge sys_clk);
        rdchk(`TCC_ADDR_MODE, 32'h0000_0009);
        wr(`TCC_ADDR_MODE, 32'h0000_0008);
        rdchk(`TCC_ADDR_MODE, 32'h0000_0008);
        wr(`TCC_ADDR_MODE, 32'h0000_0000);
    endtask : t_overflow
    // ==========================================================
    // Clock, reset, sequence and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        srst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0000_0000;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        t_regs();
        t_square();
        t_event();
        t_capture();
        t_restart();
        t_oneshot();
        t_overflow();
        give_verdict();
    end
    initial begin
        #900000;
        bad_count++;
        give_verdict();
    end
endmodule : tb_top
